/* File: logic/fps_host.sv */
/*
 * fps_host: host-side sequencer that issues program, erase, suspend, resume and
 * identification sequences to a byte-wide flash and polls it for completion.
 * assumes the flash pins are wired directly and that core_clk runs at 20 MHz.
 */
// Overview of operation
// RULE1: program is two unlocks, setup, address/data
// RULE2: after program start, host only polls
// RULE3: device returns to array read when done
// RULE4: device ignores commands while programming
// RULE5: program accepted at any address order
// RULE6: program only clears bits; flag timeout
// RULE7: chip erase is six writes ending 10
// RULE8: device preprograms itself before erase
// RULE9: chip erase ignores every command
// RULE10: sector erase six writes, sector plus 30
// RULE11: window accepts more sector writes
// RULE12: host spaces extra sectors under 50 us
// RULE13: sectors may be queued in any order
// RULE14: other command in window discards erase
// RULE15: window timed from last strobe rise
// RULE16: active sector erase only takes suspend
// RULE17: host keeps sector writes uninterrupted
// RULE18: suspend only during sector erase
// RULE19: suspend reached within 20 us
// RULE20: suspended: reads, programs elsewhere allowed
// RULE21: identification allowed while suspended
// RULE22: resume continues erase, later resumes ignored
// RULE23: fixed unlock addresses and command codes
// RULE24: address on strobe fall, data rise
// RULE25: sector taken from top three bits
// RULE26: write only with output enable high
`timescale 1ns/1ps
module fps_host
	import fps_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          reset,
	input  wire logic          req_valid,
	output logic               req_ready,
	input  wire fps_req_s      req,
	input  wire logic          req_more,
	output logic               rsp_valid,
	output logic [7:0]         rsp_data,
	output logic               rsp_error,
	output logic               erasing,
	output logic               suspended,
	output logic [16:0]        fl_addr,
	output logic [7:0]         fl_dq_out,
	output logic               fl_dq_oe,
	input  wire logic [7:0]    fl_dq_in,
	output logic               fl_ce_n,
	output logic               fl_we_n,
	output logic               fl_oe_n
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEQ,
		ST_POLL,
		ST_WINDOW,
		ST_SUSPWAIT,
		ST_RESP
	} fps_st_e;

	fps_st_e       state_reg;      // sequencer phase
	fps_req_s      req_reg;        // captured user request
	logic [2:0]    step_reg;       // index within the write sequence
	logic [2:0]    nsteps_reg;     // writes in the active sequence
	logic          busy_reg;       // bus engine has a cycle in flight
	logic          poll_rd_reg;    // current cycle is a status read
	logic [7:0]    last_rd_reg;    // previous status byte for toggle compare
	logic          first_rd_reg;   // no previous status byte yet
	logic [10:0]   win_cnt_reg;    // cycles since last sector write rise
	logic [9:0]    susp_cnt_reg;   // cycles since suspend was written
	logic          ers_reg;        // a sector erase is in progress
	logic          susp_reg;       // sector erase is suspended
	logic          chip_reg;       // chip erase in progress
	logic [7:0]    rsp_data_reg;   // answer byte
	logic          rsp_err_reg;    // answer error flag

	fps_cyc_s      cyc;            // next bus cycle
	logic          cyc_start;      // launch it
	logic          cyc_done;       // engine finished
	logic [7:0]    cyc_rdata;      // engine read data

	fps_bus_cycle u_cycle (
		.core_clk  (core_clk),
		.reset     (reset),
		.start     (cyc_start),
		.cyc       (cyc),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.fl_addr   (fl_addr),
		.fl_dq_out (fl_dq_out),
		.fl_dq_oe  (fl_dq_oe),
		.fl_dq_in  (fl_dq_in),
		.fl_ce_n   (fl_ce_n),
		.fl_we_n   (fl_we_n),
		.fl_oe_n   (fl_oe_n)
	);

	// the sector field keeps only the top three bits; the rest is zero [RULE25]
	wire [16:0] sect_addr = {req_reg.addr[SECT_MSB:SECT_LSB], 14'h0000};
	// program and identify use the short form; erase uses the long form
	wire is_prog  = (req_reg.op == FPS_OP_PROG);
	wire is_ident = (req_reg.op == FPS_OP_IDENT);
	wire is_read  = (req_reg.op == FPS_OP_READ);

	// command sequence table, indexed by step [RULE23]
	logic [16:0] seq_addr;
	logic [7:0]  seq_data;
	always_comb
	begin
		seq_addr = UNLOCK_A1;
		seq_data = UNLOCK_D1;
		case (step_reg)
			3'h0: begin seq_addr = UNLOCK_A1; seq_data = UNLOCK_D1; end
			3'h1: begin seq_addr = UNLOCK_A2; seq_data = UNLOCK_D2; end
			3'h2:
			begin
				seq_addr = UNLOCK_A1;
				seq_data = is_prog ? CMD_PROG : (is_ident ? CMD_IDENT : CMD_ERASE);
			end
			3'h3:
			begin
				// program target and value close a short sequence [RULE1]
				seq_addr = is_prog ? req_reg.addr : UNLOCK_A1;
				seq_data = is_prog ? req_reg.data : UNLOCK_D1;
			end
			3'h4: begin seq_addr = UNLOCK_A2; seq_data = UNLOCK_D2; end
			3'h5:
			begin
				// chip erase ends in 10 at 555, sector erase in 30 at the sector [RULE7] [RULE10]
				seq_addr = (req_reg.op == FPS_OP_CHIP) ? UNLOCK_A1 : sect_addr;
				seq_data = (req_reg.op == FPS_OP_CHIP) ? CMD_CHIP : CMD_SECT;
			end
			default: begin seq_addr = UNLOCK_A1; seq_data = UNLOCK_D1; end
		endcase
	end

	// pick the bus cycle to launch from the sequencer phase
	wire        in_window  = (state_reg == ST_WINDOW);
	wire        win_safe   = (win_cnt_reg < 11'(WIN_SAFE_CYC));
	// an extra sector is sent as one write inside the window [RULE11] [RULE12] [RULE13]
	wire        add_sect   = in_window && req_valid && req.op == FPS_OP_SECT && win_safe;
	// single-write commands carry no unlock prefix
	wire        one_write  = (req_reg.op == FPS_OP_SUSP) || (req_reg.op == FPS_OP_RESUME)
	                         || (req_reg.op == FPS_OP_RESET);
	wire [7:0]  one_data   = (req_reg.op == FPS_OP_SUSP) ? CMD_SUSP :
	                         (req_reg.op == FPS_OP_RESUME) ? CMD_RESUME : CMD_RESET;

	always_comb
	begin
		cyc.wr   = 1'b1;
		cyc.addr = seq_addr;
		cyc.data = seq_data;
		if (poll_rd_reg || is_read)
		begin
			cyc.wr   = 1'b0;
			cyc.addr = req_reg.addr;   // read or program target; erase polls use the last accepted request's address
		end
		else if (one_write)
		begin
			cyc.addr = 17'h00000;     // address ignored by the device [RULE18] [RULE22]
			cyc.data = one_data;
		end
	end

	assign cyc_start = !busy_reg && (state_reg == ST_SEQ || state_reg == ST_POLL);

	// a request is refused while a chip erase or program runs [RULE4] [RULE9] [RULE16]
	// suspend only offered during sector erase [RULE18]; resume only when suspended [RULE22]
	wire op_legal = !ers_reg && !chip_reg ? (req.op != FPS_OP_SUSP && req.op != FPS_OP_RESUME) :
	                susp_reg ? (req.op != FPS_OP_SUSP && req.op != FPS_OP_CHIP && req.op != FPS_OP_SECT) :
	                (ers_reg && req.op == FPS_OP_SUSP);
	assign req_ready = ((state_reg == ST_IDLE) && op_legal) || add_sect;
	assign rsp_valid = (state_reg == ST_RESP);
	assign rsp_data  = rsp_data_reg;
	assign rsp_error = rsp_err_reg;
	assign erasing   = ers_reg || chip_reg;
	assign suspended = susp_reg;

	// toggle stops when the internal algorithm ends, device back in array read [RULE3]
	wire toggling = !first_rd_reg && (cyc_rdata[TOGGLE_BIT] != last_rd_reg[TOGGLE_BIT]);
	wire tout_hit = cyc_rdata[TOUT_BIT];

	// sequencer: issue writes, then poll the status bits for completion
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_reg    <= ST_IDLE;
			req_reg      <= '0;
			step_reg     <= 3'h0;
			nsteps_reg   <= 3'h0;
			busy_reg     <= 1'b0;
			poll_rd_reg  <= 1'b0;
			last_rd_reg  <= 8'h00;
			first_rd_reg <= 1'b1;
			win_cnt_reg  <= 11'h000;
			susp_cnt_reg <= 10'h000;
			ers_reg      <= 1'b0;
			susp_reg     <= 1'b0;
			chip_reg     <= 1'b0;
			rsp_data_reg <= 8'h00;
			rsp_err_reg  <= 1'b0;
		end
		else
		begin
			if (cyc_start)
				busy_reg <= 1'b1;
			else if (cyc_done)
				busy_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (req_valid && req_ready)
					begin
						// any address order is fine for programs [RULE5]
						req_reg      <= req;
						step_reg     <= 3'h0;
						poll_rd_reg  <= 1'b0;
						first_rd_reg <= 1'b1;
						rsp_err_reg  <= 1'b0;
						nsteps_reg   <= (req.op == FPS_OP_PROG || req.op == FPS_OP_IDENT) ? 3'h4 : 3'h6;
						if (req.op == FPS_OP_IDENT)
							nsteps_reg <= 3'h3;
						state_reg    <= ST_SEQ;
					end
					else if (erasing && !susp_reg)
					begin
						// erase runs in the background; one status read between requests [RULE3]
						poll_rd_reg <= 1'b1;
						state_reg   <= ST_POLL;
					end
				end
				ST_SEQ:
				begin
					if (cyc_done)
					begin
						if (is_read || one_write || step_reg == nsteps_reg - 3'h1)
						begin
							rsp_data_reg <= cyc_rdata;
							if (req_reg.op == FPS_OP_PROG)
							begin
								// program runs on its own; host only polls [RULE2] [RULE6]
								poll_rd_reg <= 1'b1;
								state_reg   <= ST_POLL;
							end
							else if (req_reg.op == FPS_OP_CHIP)
							begin
								chip_reg    <= 1'b1;   // device preprograms itself [RULE8]
								state_reg   <= ST_RESP;
							end
							else if (req_reg.op == FPS_OP_SECT)
							begin
								ers_reg     <= 1'b1;
								win_cnt_reg <= 11'h000;  // window counted from strobe rise [RULE15]
								state_reg   <= ST_WINDOW;
							end
							else if (req_reg.op == FPS_OP_SUSP)
							begin
								susp_cnt_reg <= 10'h000;
								state_reg    <= ST_SUSPWAIT;
							end
							else if (req_reg.op == FPS_OP_RESUME)
							begin
								susp_reg  <= 1'b0;   // erase continues [RULE22]
								state_reg <= ST_RESP;
							end
							else
							begin
								// reset clears identify mode; device reverts to suspend if it was [RULE21]
								state_reg <= ST_RESP;
							end
						end
						else
							step_reg <= step_reg + 3'h1;
					end
				end
				ST_WINDOW:
				begin
					// hold the sequence off other traffic while sectors are queued [RULE17]
					win_cnt_reg <= win_cnt_reg + 11'h001;
					if (add_sect)
					begin
						req_reg     <= req;
						step_reg    <= 3'h5;
						nsteps_reg  <= 3'h6;
						state_reg   <= ST_SEQ;
					end
					else if (!req_more || !win_safe)
					begin
						// no other command in the window, else the erase is lost [RULE14]
						state_reg   <= ST_RESP;
					end
				end
				ST_POLL:
				begin
					if (cyc_done)
					begin
						first_rd_reg <= 1'b0;
						last_rd_reg  <= cyc_rdata;
						if (!first_rd_reg && !toggling)
						begin
							// program result checked against written value [RULE6]
							rsp_data_reg <= cyc_rdata;
							rsp_err_reg  <= is_prog && ((cyc_rdata & req_reg.data) != req_reg.data);
							chip_reg     <= 1'b0;
							if (!is_prog)
								ers_reg <= 1'b0;
							poll_rd_reg  <= 1'b0;
							state_reg    <= ST_RESP;
						end
						else if (!first_rd_reg && tout_hit)
						begin
							rsp_data_reg <= cyc_rdata;
							rsp_err_reg  <= 1'b1;
							chip_reg     <= 1'b0;
							ers_reg      <= is_prog ? ers_reg : 1'b0;
							poll_rd_reg  <= 1'b0;
							state_reg    <= ST_RESP;
						end
						else if (!is_prog)
							state_reg <= ST_IDLE;   // erase still busy: let suspend in
					end
				end
				ST_SUSPWAIT:
				begin
					// allow the full suspend latency before reads elsewhere [RULE19] [RULE20]
					susp_cnt_reg <= susp_cnt_reg + 10'h001;
					if (susp_cnt_reg == 10'(SUSP_CYC))
					begin
						susp_reg  <= 1'b1;
						state_reg <= ST_RESP;
					end
				end
				ST_RESP:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

/* File: include/fps_pkg.sv */
/*
 * fps_pkg: constants, commands and carrier types for the host-side flash sequencer.
 * assumes a byte-wide parallel flash with 17 address bits and active-low strobes.
 */
package fps_pkg;

	// bus geometry
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int SECT_MSB = 16;
	localparam int SECT_LSB = 14;

	// clock and timing
	localparam int CLK_NS = 50;
	localparam int WIN_US = 50;
	localparam int SUSP_MAX_US = 20;
	localparam int WIN_CYC = (WIN_US * 1000) / CLK_NS;
	localparam int SUSP_CYC = (SUSP_MAX_US * 1000 + CLK_NS - 1) / CLK_NS;
	// margin kept under the acceptance window when queuing more sectors
	localparam int WIN_SAFE_CYC = WIN_CYC / 2;
	localparam int STRB_CYC = 2;

	// unlock addresses and command codes
	localparam logic [16:0] UNLOCK_A1 = 17'h00555;
	localparam logic [16:0] UNLOCK_A2 = 17'h002AA;
	localparam logic [7:0] UNLOCK_D1 = 8'hAA;
	localparam logic [7:0] UNLOCK_D2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'hA0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_SUSP = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hF0;

	// status bit positions on the data bus
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int TOUT_BIT = 5;
	localparam int WIN_BIT = 3;

	// user commands
	typedef enum logic [2:0] {
		FPS_OP_READ,
		FPS_OP_PROG,
		FPS_OP_CHIP,
		FPS_OP_SECT,
		FPS_OP_SUSP,
		FPS_OP_RESUME,
		FPS_OP_IDENT,
		FPS_OP_RESET
	} fps_op_e;

	// one user request
	typedef struct packed {
		fps_op_e op;
		logic [16:0] addr;
		logic [7:0] data;
	} fps_req_s;

	// one bus cycle handed to the strobe engine
	typedef struct packed {
		logic wr;
		logic [16:0] addr;
		logic [7:0] data;
	} fps_cyc_s;

endpackage

/* File: logic/fps_bus_cycle.sv */
/*
 * fps_bus_cycle: drives one read or write cycle on the flash pins.
 * assumes a single core clock; the flash samples address on the strobe fall and data on its rise.
 */
`timescale 1ns/1ps
module fps_bus_cycle
	import fps_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          reset,
	input  wire logic          start,
	input  wire fps_cyc_s      cyc,
	output logic               done,
	output logic [7:0]         rdata,
	output logic [16:0]        fl_addr,
	output logic [7:0]         fl_dq_out,
	output logic               fl_dq_oe,
	input  wire logic [7:0]    fl_dq_in,
	output logic               fl_ce_n,
	output logic               fl_we_n,
	output logic               fl_oe_n
);

	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_DONE} fps_bc_e;

	fps_bc_e       state_reg;   // engine phase
	logic [1:0]    cnt_reg;     // strobe width counter
	logic          wr_reg;      // current cycle is a write

	// write strobe only with output enable high [RULE26]
	assign fl_we_n = !(state_reg == BC_STROBE && wr_reg);
	assign fl_oe_n = !(state_reg == BC_STROBE && !wr_reg);
	assign fl_ce_n = (state_reg == BC_IDLE);
	assign done    = (state_reg == BC_DONE);
	// data stays driven through the setup and strobe phases so the rising edge latches it [RULE24]
	assign fl_dq_oe = wr_reg && (state_reg != BC_IDLE);

	// sequence: address setup, strobe for STRB_CYC cycles, then release
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_reg <= BC_IDLE;
			cnt_reg   <= 2'h0;
			wr_reg    <= 1'b0;
			fl_addr   <= 17'h00000;
			fl_dq_out <= 8'h00;
			rdata     <= 8'h00;
		end
		else
		begin
			case (state_reg)
				BC_IDLE:
				begin
					if (start)
					begin
						// address set before strobes fall [RULE24]
						wr_reg    <= cyc.wr;
						fl_addr   <= cyc.addr;
						fl_dq_out <= cyc.data;
						state_reg <= BC_SETUP;
					end
				end
				BC_SETUP:
				begin
					cnt_reg   <= 2'(STRB_CYC - 1);
					state_reg <= BC_STROBE;
				end
				BC_STROBE:
				begin
					if (cnt_reg == 2'h0)
					begin
						rdata     <= fl_dq_in;   // sampled while output enable is low
						state_reg <= BC_DONE;
					end
					else
						cnt_reg <= cnt_reg - 2'h1;
				end
				BC_DONE:
					state_reg <= BC_IDLE;
				default:
					state_reg <= BC_IDLE;
			endcase
		end
	end

endmodule

/* File: testbench/fps_host_assertions.sv */
/*
 * fps_host_assertions: checks on the flash strobes, command order and user handshake of fps_host.
 * assumes it is bound to fps_host and sees only that module's ports.
 */
`timescale 1ns/1ps
module fps_host_assertions
	import fps_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire fps_req_s    req,
	input wire logic        req_more,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_data,
	input wire logic        rsp_error,
	input wire logic        erasing,
	input wire logic        suspended,
	input wire logic [16:0] fl_addr,
	input wire logic [7:0]  fl_dq_out,
	input wire logic        fl_dq_oe,
	input wire logic [7:0]  fl_dq_in,
	input wire logic        fl_ce_n,
	input wire logic        fl_we_n,
	input wire logic        fl_oe_n
);
	logic [16:0] prev_a;  // address of the last finished write
	logic [7:0]  prev_d;  // data of the last finished write
	logic [15:0] gap_cnt; // cycles since that write, saturating

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// remember each finished write, so order checks can look one write back
	always_ff @(posedge core_clk)
		if ($rose(fl_we_n))
		begin
			prev_a <= fl_addr;
			prev_d <= fl_dq_out;
		end

	// spacing between writes; saturates so a long erase cannot wrap it
	always_ff @(posedge core_clk)
		if (reset || $rose(fl_we_n))
			gap_cnt <= 16'h0000;
		else if (gap_cnt != 16'hFFFF)
			gap_cnt <= gap_cnt + 16'h0001;

	property p_write_gate;
		!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe;
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("write strobe without select");

	property p_read_gate;
		!fl_oe_n |-> fl_we_n && !fl_dq_oe;
	endproperty
	a_read_gate: assert property (p_read_gate) else $error("read strobe while writing");

	property p_we_width;
		$fell(fl_we_n) |=> !fl_we_n ##1 fl_we_n;
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe not two cycles");

	property p_hold;
		!fl_we_n ##1 !fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out);
	endproperty
	a_hold: assert property (p_hold) else $error("bus moved under write strobe");

	property p_prog_order;
		$rose(fl_we_n) && fl_addr == UNLOCK_A1 && fl_dq_out == CMD_PROG |-> prev_d == UNLOCK_D2;
	endproperty
	a_prog_order: assert property (p_prog_order) else $error("program setup not after unlock");

	property p_unlock;
		$rose(fl_we_n) && fl_addr == UNLOCK_A2 && fl_dq_out == UNLOCK_D2 |-> prev_a == UNLOCK_A1 && prev_d == UNLOCK_D1;
	endproperty
	a_unlock: assert property (p_unlock) else $error("second unlock out of order");

	property p_susp_only;
		$rose(fl_we_n) && fl_dq_out == CMD_SUSP |-> erasing && !suspended;
	endproperty
	a_susp_only: assert property (p_susp_only) else $error("suspend outside sector erase");

	property p_win_gap;
		$rose(fl_we_n) && fl_dq_out == CMD_SECT && prev_d == CMD_SECT && !suspended |-> gap_cnt < WIN_CYC;
	endproperty
	a_win_gap: assert property (p_win_gap) else $error("queued sector too late");

	property p_resume_ready;
		req_ready && req.op == FPS_OP_RESUME |-> suspended;
	endproperty
	a_resume_ready: assert property (p_resume_ready) else $error("resume offered while not held");

	c_susp: cover property ($rose(suspended));
	c_erase_done: cover property ($fell(erasing));
	c_queue: cover property ($rose(fl_we_n) && fl_dq_out == CMD_SECT && prev_d == CMD_SECT);
endmodule

bind fps_host fps_host_assertions u_fps_host_assertions (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .req_more(req_more), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.rsp_error(rsp_error), .erasing(erasing), .suspended(suspended), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
	.fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));

/* File: testbench/fps_flash_model.sv */
/*
 * fps_flash_model: behavioural byte-wide flash with program, erase, suspend and identification.
 * assumes active-low strobes from the host; internal time runs in 50 ns ticks.
 */
`timescale 1ns/1ps
module fps_flash_model
	import fps_pkg::*;
#(
	parameter logic [7:0] ID_CODE = 8'h5A // arbitrary identification value
)
(
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [16:0] addr,
	input  wire logic [7:0]  din,
	output logic      [7:0]  dout
);
	logic [7:0]  mem [0:131071]; // array contents
	logic [7:0]  esect = '0;     // sectors queued for erase
	logic [7:0]  pdat = '0;      // byte being programmed
	logic [7:0]  hold = '0;      // last byte put on the bus
	logic [16:0] la;             // address taken at the later strobe fall
	logic        wact = 0;       // write cycle open
	logic        tog = 0;        // toggling status bit
	logic        ident = 0;      // identification mode
	int          busy = 0;       // 0 read 1 prog 2 chip 3 window 4 erase 5 held
	int          step = 0;       // position in an unlock sequence
	int          tmr = 0;        // ticks left of the running step
	int          sus = 0;        // ticks until suspension lands
	int          keep = 0;       // erase ticks saved while held
	int          ret = 0;        // state to return to after a program
	wire         stat = busy inside {[1:4]} || (busy == 5 && esect[addr[16:14]]);
	wire [7:0]   rv = ident ? ID_CODE : stat ? {busy == 1 ? ~pdat[7] : 1'h0, tog, 2'h0, busy == 4, 3'h0} : mem[addr];

	initial
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'hFF;

	// a released bus shows the inverse of the last byte, so stale data never passes
	always @*
		if (!ce_n && !oe_n)
			hold = rv;
	assign dout = (!ce_n && !oe_n) ? rv : ~hold;
	always @(posedge oe_n)
		if (stat)
			tog = ~tog; // status moves on each read while busy

	// write cycle framing
	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n && oe_n)
		begin
			wact = 1;
			la = addr;
		end
	always @(posedge we_n or posedge ce_n)
		if (wact)
		begin
			wact = 0;
			wr(la, din);
		end

	// command decoder
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		if (busy inside {1, 2} || (busy == 4 && sus > 0))
			return;
		if (busy == 4)
		begin
			if (d == CMD_SUSP)
				sus = 200; // 10 us, under the 20 us limit
			return; // repeated resume ignored
		end
		if (busy == 3)
		begin
			if (d == CMD_SUSP)
			begin
				keep = 2000;
				busy = 5; // window ends at once
			end
			else if (d == CMD_SECT)
			begin
				esect[a[16:14]] = 1'h1;
				tmr = 1000; // 50 us from this strobe rise
			end
			else
			begin
				busy = 0;
				esect = '0;
			end
			return;
		end
		if (d == CMD_RESET)
		begin
			ident = 0; // leaving identification keeps the held erase
			step = 0;
			return;
		end
		if (busy == 5 && step == 0 && d == CMD_RESUME)
		begin
			busy = 4;
			tmr = keep;
			return;
		end
		case (step)
			0, 3: step = (a == UNLOCK_A1 && d == UNLOCK_D1) ? step + 1 : 0;
			1, 4: step = (a == UNLOCK_A2 && d == UNLOCK_D2) ? step + 1 : 0;
			2: step = a != UNLOCK_A1 ? 0 : d == CMD_PROG ? 6 : (d == CMD_ERASE && busy == 0) ? 3 : d == CMD_IDENT ? 7 : 0;
			5:
			begin
				step = 0;
				if (d == CMD_CHIP && a == UNLOCK_A1)
				begin
					esect = 8'hFF;
					busy = 2;
					tmr = 2000;
				end
				else if (d == CMD_SECT)
				begin
					esect = 8'h00;
					esect[a[16:14]] = 1'h1;
					busy = 3;
					tmr = 1000;
				end
			end
			6:
			begin
				step = 0;
				mem[a] = mem[a] & d; // bits only clear
				pdat = d;
				ret = busy;
				busy = 1;
				tmr = 40;
			end
			default: step = 0;
		endcase
		if (step == 7)
		begin
			ident = 1;
			step = 0;
		end
	endtask

	// end of an internal step
	task automatic done_op;
		if (busy == 3)
		begin
			busy = 4; // window ran out
			tmr = 2000;
			return;
		end
		if (busy != 1)
			for (int i = 0; i < 131072; i++)
				if (esect[i[16:14]])
					mem[i] = 8'hFF; // preprogram and erase done internally
		busy = busy == 1 ? ret : 0;
	endtask

	// internal timebase; free-running, unrelated to the host clock
	always #50
		if (sus > 0)
		begin
			sus--;
			if (sus == 0)
			begin
				keep = tmr;
				busy = 5;
			end
		end
		else if (busy inside {[1:4]} && tmr > 0)
		begin
			tmr--;
			if (tmr == 0)
				done_op();
		end
endmodule

/* File: testbench/fps_host_bench.sv */
/*
 * fps_host_bench: self-checking bench for fps_host against the behavioural flash.
 * assumes fps_pkg and fps_flash_model; core clock 20 MHz.
 */
`timescale 1ns/1ps
module fps_host_bench
	import fps_pkg::*;
;
	localparam logic [7:0] ID = 8'h5A; // arbitrary identification value
	logic        core_clk = 0, reset = 1, req_valid = 0, req_more = 0;
	fps_req_s    req = '0;
	logic        req_ready, rsp_valid, rsp_error, erasing, suspended, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
	logic [7:0]  rsp_data, fl_dq_out, fl_dq_in, dq_flash;
	logic [16:0] fl_addr;
	int          n_mismatch = 0, cmp_count = 0, cyc = 0;

	// data line level: host while it drives, else the flash
	assign fl_dq_in = fl_dq_oe ? fl_dq_out : dq_flash;

	fps_host u_fps_host (.core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .req_more(req_more), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
		.erasing(erasing), .suspended(suspended), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
		.fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
	fps_flash_model #(.ID_CODE(ID)) u_fps_flash_model (.ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
		.addr(fl_addr), .din(fl_dq_in), .dout(dq_flash));

	initial
		forever #25 core_clk = ~core_clk;

	// hang guard: generous for a few erases
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one user request: hold until taken, then wait for its answer unless more is set
	task automatic op(input fps_op_e o, input logic [16:0] a, input logic [7:0] d, input logic more);
		int n;
		@(negedge core_clk);
		req = '{o, a, d};
		req_more = more;
		req_valid = 1;
		n = 0;
		#1;
		while (req_ready !== 1'b1 && n < 2000)
		begin
			@(negedge core_clk);
			#1;
			n++;
		end
		@(negedge core_clk);
		req_valid = 0;
		n = 0;
		while (rsp_valid !== 1'b1 && !more && n < 30000)
		begin
			@(negedge core_clk);
			n++;
		end
		check({7'h00, n < 30000}, 8'h01);
	endtask

	task automatic rd(input logic [16:0] a, input logic [7:0] exp);
		op(FPS_OP_READ, a, 8'h00, 0);
		check(rsp_data, exp);
	endtask

	task automatic refused(input fps_op_e o);
		@(negedge core_clk);
		req.op = o;
		#1 check({7'h00, req_ready}, 8'h00);
	endtask

	// bounded wait for an outstanding erase to finish
	task automatic wait_idle;
		int n;
		n = 0;
		while (erasing !== 1'b0 && n < 20000)
		begin
			@(negedge core_clk);
			n++;
		end
		check({7'h00, erasing}, 8'h00);
	endtask

	task automatic t_prog;
		op(FPS_OP_PROG, 17'h1FFFF, 8'hA5, 0);
		check({7'h00, rsp_error}, 8'h00);
		op(FPS_OP_PROG, 17'h00000, 8'h3C, 0);
		rd(17'h1FFFF, 8'hA5);
		rd(17'h00000, 8'h3C);
	endtask

	task automatic t_clear;
		op(FPS_OP_PROG, 17'h1FFFF, 8'h5A, 0);
		rd(17'h1FFFF, 8'h00);
	endtask

	task automatic t_chip;
		op(FPS_OP_CHIP, 17'h00000, 8'h00, 0);
		check({7'h00, erasing}, 8'h01);
		refused(FPS_OP_SUSP);
		wait_idle();
		rd(17'h1FFFF, 8'hFF);
	endtask

	task automatic t_sect;
		op(FPS_OP_PROG, 17'h08000, 8'h00, 0);
		op(FPS_OP_PROG, 17'h04000, 8'h00, 0);
		op(FPS_OP_PROG, 17'h0C000, 8'h00, 0);
		op(FPS_OP_SECT, 17'h08000, 8'h00, 1);
		op(FPS_OP_SECT, 17'h04000, 8'h00, 0);
		wait_idle();
		rd(17'h08000, 8'hFF);
		rd(17'h04000, 8'hFF);
		rd(17'h0C000, 8'h00);
	endtask

	task automatic t_susp;
		op(FPS_OP_SECT, 17'h0C000, 8'h00, 0);
		repeat (1200) @(negedge core_clk); // past the 50 us window
		op(FPS_OP_SUSP, 17'h00000, 8'h00, 0);
		check({7'h00, suspended}, 8'h01);
		refused(FPS_OP_CHIP);
		op(FPS_OP_PROG, 17'h10000, 8'h77, 0);
		rd(17'h10000, 8'h77);
		op(FPS_OP_IDENT, 17'h00000, 8'h00, 0);
		rd(17'h0C000, ID);
		op(FPS_OP_RESET, 17'h00000, 8'h00, 0);
		check({7'h00, suspended}, 8'h01);
		op(FPS_OP_RESUME, 17'h00000, 8'h00, 0);
		check({7'h00, suspended}, 8'h00);
		wait_idle();
		rd(17'h0C000, 8'hFF);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(negedge core_clk);
		reset = 0;
		t_prog();
		t_clear();
		t_chip();
		t_sect();
		t_susp();
		final_report();
	end
endmodule
